// file: src/fec_flash_erase_controller.v
// Flash erase and protection controller with APB register access.
// Assumes clock inputs from the clock system are asynchronous
// levels; they are synchronised and edge-detected on clk_sys_i.
`timescale 1ns/1ps
`include "fec_defines.vh"
module fec_flash_erase_controller #(
	parameter MAIN_SEGS = 8,
	parameter ADDR_W = 13
) (
	input wire clk_sys_i,
	input wire reset_n_i,
	input wire clk_en_i,
	input wire aux_clock_i,
	input wire sub_main_clock_i,
	input wire main_clock_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output reg pready_o,
	output reg pslverr_o,
	output reg busy_o,
	output reg cpu_stall_o,
	output reg timing_clock_on_o,
	output reg prog_voltage_on_o,
	output reg erase_pulse_o,
	output reg [ADDR_W-1:0] erase_base_o,
	output reg [ADDR_W-1:0] erase_len_o,
	output reg program_pulse_o,
	output reg [ADDR_W-1:0] program_addr_o,
	output reg [7:0] program_mask_o
);
	// ************************************************
	// Address map of the array
	// ************************************************
	localparam [ADDR_W-1:0] INFO_BYTES =
		`FEC_INFO_SEGS * `FEC_INFO_SEG_BYTES;
	localparam [ADDR_W-1:0] INFO_SEG = `FEC_INFO_SEG_BYTES;
	localparam [ADDR_W-1:0] MAIN_SEG = `FEC_MAIN_SEG_BYTES;
	localparam [ADDR_W-1:0] MAIN_BYTES = MAIN_SEGS * `FEC_MAIN_SEG_BYTES;
	localparam [ADDR_W-1:0] ALL_BYTES = INFO_BYTES + MAIN_BYTES;
	localparam [ADDR_W-1:0] BLOCK_MASK = ~(`FEC_BLOCK_BYTES - 1);
	// ************************************************
	// Controller states
	// ************************************************
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_ERASE = 4'h2;
	localparam [3:0] ST_PROG = 4'h4;
	localparam [3:0] ST_END = 4'h8;
	reg [3:0] state;
	reg [5:0] ctrl;
	reg [7:0] clk_cfg;
	reg info_seg_a_lock;
	reg fail;
	reg accv;
	reg [ADDR_W-1:0] acc_addr;
	reg [7:0] acc_data;
	reg [15:0] tick_cnt;
	reg [5:0] div_cnt;
	reg [7:0] watch_cnt;
	reg [2:0] sync_aux, sync_sub, sync_main;
	wire acc_strobe = psel_i & penable_i & pready_o;
	wire wr = acc_strobe & pwrite_i;
	wire active = (state == ST_ERASE) | (state == ST_PROG);
	// ************************************************
	// Clock source synchronisation and selection
	// ************************************************
	always @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			sync_aux <= 3'h0;
			sync_sub <= 3'h0;
			sync_main <= 3'h0;
		end else if (clk_en_i) begin
			sync_aux <= {sync_aux[1:0], aux_clock_i};
			sync_sub <= {sync_sub[1:0], sub_main_clock_i};
			sync_main <= {sync_main[1:0], main_clock_i};
		end
	end
	wire [1:0] src_sel = clk_cfg[`FEC_CLK_SEL_HI:`FEC_CLK_SEL_LO];
	wire [5:0] timing_clock_divider =
		clk_cfg[`FEC_CLK_DIV_HI:`FEC_CLK_DIV_LO];
	reg [2:0] src_sync;
	always @* begin
		case (src_sel)
		`FEC_SRC_AUX: src_sync = sync_aux;
		`FEC_SRC_SUBMAIN: src_sync = sync_sub;
		default: src_sync = sync_main;
		endcase
	end
	// Rising edge uses only second and third stages
	wire src_edge = src_sync[1] & ~src_sync[2];
	wire ftg_tick = active & src_edge & (div_cnt == timing_clock_divider);
	wire clk_failed = active & (watch_cnt == `FEC_CLKFAIL_LIMIT);
	// ************************************************
	// Range decode of the dummy write
	// ************************************************
	wire in_info = acc_addr < INFO_BYTES;
	wire in_array = acc_addr < ALL_BYTES;
	wire in_seg_a = acc_addr < INFO_SEG;
	wire do_erase = ctrl[`FEC_CTL_ERASE];
	wire do_mass = ctrl[`FEC_CTL_MASS];
	wire do_prog = ctrl[`FEC_CTL_PROG];
	reg range_ok;
	reg [ADDR_W-1:0] next_base, next_len;
	always @* begin
		range_ok = 1'b0;
		next_base = {ADDR_W{1'b0}};
		next_len = {ADDR_W{1'b0}};
		case ({do_mass, do_erase})
		2'b01: begin
			// Segment is the smallest erase unit
			range_ok = in_array & ~(in_seg_a & info_seg_a_lock);
			if (in_info) begin
				next_base = acc_addr & ~(INFO_SEG - 1'b1);
				next_len = INFO_SEG;
			end else begin
				next_base = ((acc_addr - INFO_BYTES) & ~(MAIN_SEG - 1'b1))
					+ INFO_BYTES;
				next_len = MAIN_SEG;
			end
		end
		2'b10: begin
			range_ok = in_array & ~in_info;
			next_base = INFO_BYTES;
			next_len = MAIN_BYTES;
		end
		2'b11: begin
			// Locked: info area spared, only main is the range
			range_ok = info_seg_a_lock ? (in_array & ~in_info) : in_array;
			next_base = info_seg_a_lock ? INFO_BYTES : {ADDR_W{1'b0}};
			next_len = info_seg_a_lock ? MAIN_BYTES : ALL_BYTES;
		end
		default: begin
			range_ok = 1'b0;
		end
		endcase
	end
	wire prog_ok = in_array & ~(in_seg_a & info_seg_a_lock);
	// ************************************************
	// Register bus and control state
	// ************************************************
	wire go = wr & (paddr_i == `FEC_OFF_ACC) & pwdata_i[`FEC_ACC_GO];
	wire touch = acc_strobe & (paddr_i == `FEC_OFF_ACC) &
		~pwdata_i[`FEC_ACC_DUMMY];
	wire start_erase = go & ~active & (do_erase | do_mass) & range_ok;
	wire start_prog = go & ~active & do_prog & ~do_erase & ~do_mass &
		prog_ok;
	reg [31:0] next_rdata;
	always @* begin
		next_rdata = 32'h0000_0000;
		case (paddr_i)
		`FEC_OFF_CTRL: next_rdata = {26'h0, ctrl};
		`FEC_OFF_CLK: next_rdata = {24'h0, clk_cfg};
		`FEC_OFF_STAT: next_rdata = {26'h0, timing_clock_on_o, cpu_stall_o,
			info_seg_a_lock, accv, fail, busy_o};
		`FEC_OFF_ADDR: next_rdata = {{(32-ADDR_W){1'b0}}, acc_addr};
		`FEC_OFF_DATA: next_rdata = {24'h0, acc_data};
		`FEC_OFF_ACC: next_rdata = 32'h0000_0000;
		default: next_rdata = 32'h0000_0000;
		endcase
	end
	wire mapped = (paddr_i <= `FEC_OFF_ACC) & (paddr_i[1:0] == 2'h0);
	always @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else if (clk_en_i) begin
			// One wait state: ready in the second access cycle
			pready_o <= psel_i & penable_i & ~pready_o;
			pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
			if (psel_i & penable_i & ~pready_o & ~pwrite_i)
				prdata_o <= next_rdata;
		end
	end
	always @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			ctrl <= `FEC_RST_CTRL;
			clk_cfg <= `FEC_RST_CLK;
			info_seg_a_lock <= `FEC_RST_INFO_SEG_A_LOCK;
			fail <= 1'b0;
			accv <= 1'b0;
			acc_addr <= {ADDR_W{1'b0}};
			acc_data <= 8'hFF;
		end else if (clk_en_i) begin
			// Mode bits stay frozen while an operation runs
			if (wr & (paddr_i == `FEC_OFF_CTRL) & ~active)
				ctrl <= pwdata_i[5:0];
			else if ((state == ST_END) & ~do_prog)
				ctrl <= ctrl & ~6'h0C;
			if (wr & (paddr_i == `FEC_OFF_CLK) & ~active)
				clk_cfg <= pwdata_i[7:0];
			if (wr & (paddr_i == `FEC_OFF_STAT) &
				pwdata_i[`FEC_ST_INFO_SEG_A_LOCK] & ~active)
				info_seg_a_lock <= ~info_seg_a_lock;
			// Set wins over a software clear in the same cycle
			if (clk_failed)
				fail <= 1'b1;
			else if (wr & (paddr_i == `FEC_OFF_STAT) & pwdata_i[`FEC_ST_FAIL])
				fail <= 1'b0;
			if (touch & active & ~cpu_stall_o)
				accv <= 1'b1;
			else if (wr & (paddr_i == `FEC_OFF_STAT) & pwdata_i[`FEC_ST_ACCV])
				accv <= 1'b0;
			if (wr & (paddr_i == `FEC_OFF_ADDR) & ~active)
				acc_addr <= pwdata_i[ADDR_W-1:0];
			if (wr & (paddr_i == `FEC_OFF_DATA) & ~active)
				acc_data <= pwdata_i[7:0];
		end
	end
	// ************************************************
	// Operation sequencer
	// ************************************************
	always @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			state <= ST_IDLE;
			tick_cnt <= 16'h0000;
			div_cnt <= 6'h00;
			watch_cnt <= 8'h00;
			busy_o <= 1'b0;
			cpu_stall_o <= 1'b0;
			timing_clock_on_o <= 1'b0;
			prog_voltage_on_o <= 1'b0;
			erase_pulse_o <= 1'b0;
			erase_base_o <= {ADDR_W{1'b0}};
			erase_len_o <= {ADDR_W{1'b0}};
			program_pulse_o <= 1'b0;
			program_addr_o <= {ADDR_W{1'b0}};
			program_mask_o <= 8'hFF;
		end else if (clk_en_i) begin
			erase_pulse_o <= 1'b0;
			program_pulse_o <= 1'b0;
			if (src_edge | ~active)
				watch_cnt <= 8'h00;
			else
				watch_cnt <= watch_cnt + 8'h01;
			if (active & src_edge)
				div_cnt <= (div_cnt == timing_clock_divider) ? 6'h00 :
					div_cnt + 6'h01;
			else if (~active)
				div_cnt <= 6'h00;
			case (state)
			ST_IDLE: begin
				// Read mode: generators off, array read only
				timing_clock_on_o <= 1'b0;
				prog_voltage_on_o <= 1'b0;
				tick_cnt <= 16'h0000;
				if (start_erase) begin
					state <= ST_ERASE;
					busy_o <= 1'b1;
					timing_clock_on_o <= 1'b1;
					prog_voltage_on_o <= 1'b1;
					cpu_stall_o <= ctrl[`FEC_CTL_FROM_FLASH];
					erase_base_o <= next_base;
					erase_len_o <= next_len;
				end else if (start_prog) begin
					state <= ST_PROG;
					busy_o <= 1'b1;
					timing_clock_on_o <= 1'b1;
					prog_voltage_on_o <= 1'b1;
					cpu_stall_o <= ctrl[`FEC_CTL_FROM_FLASH] &
						~ctrl[`FEC_CTL_BLK];
					program_addr_o <= acc_addr;
					// Program may only pull bits to zero
					program_mask_o <= acc_data;
				end
			end
			ST_ERASE: begin
				// Timing clock held on regardless of low power
				timing_clock_on_o <= 1'b1;
				if (clk_failed) begin
					state <= ST_END;
				end else if (ftg_tick) begin
					tick_cnt <= tick_cnt + 16'h0001;
					// Fixed tick count, whatever the array size
					if (tick_cnt == `FEC_ERASE_TICKS - 16'h0001) begin
						state <= ST_END;
						erase_pulse_o <= 1'b1;
					end
				end
			end
			ST_PROG: begin
				timing_clock_on_o <= 1'b1;
				if (clk_failed) begin
					state <= ST_END;
				end else if (ftg_tick) begin
					tick_cnt <= tick_cnt + 16'h0001;
					if (tick_cnt == `FEC_PROG_TICKS - 16'h0001) begin
						state <= ST_END;
						program_pulse_o <= 1'b1;
						program_addr_o <= program_addr_o;
					end
				end
			end
			ST_END: begin
				state <= ST_IDLE;
				busy_o <= 1'b0;
				cpu_stall_o <= 1'b0;
				prog_voltage_on_o <= 1'b0;
				timing_clock_on_o <= ~ctrl[`FEC_CTL_LOWPWR];
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end
endmodule // fec_flash_erase_controller

// file: src/fec_defines.vh
// Constants for the flash erase controller: register offsets, fields,
// reset values and timing counts.
// Assumes inclusion by bare name from the design file.
`ifndef FEC_DEFINES_VH
`define FEC_DEFINES_VH
`define FEC_OFF_CTRL 12'h000
`define FEC_OFF_CLK 12'h004
`define FEC_OFF_STAT 12'h008
`define FEC_OFF_ADDR 12'h00C
`define FEC_OFF_DATA 12'h010
`define FEC_OFF_ACC 12'h014
// Control register fields
`define FEC_CTL_PROG 0
`define FEC_CTL_BLK 1
`define FEC_CTL_ERASE 2
`define FEC_CTL_MASS 3
`define FEC_CTL_FROM_FLASH 4
`define FEC_CTL_LOWPWR 5
// Clock register fields
`define FEC_CLK_SEL_LO 0
`define FEC_CLK_SEL_HI 1
`define FEC_CLK_DIV_LO 2
`define FEC_CLK_DIV_HI 7
// Status register fields
`define FEC_ST_BUSY 0
`define FEC_ST_FAIL 1
`define FEC_ST_ACCV 2
`define FEC_ST_INFO_SEG_A_LOCK 3
`define FEC_ST_STALL 4
`define FEC_ST_TCLK_ON 5
// Access register fields
`define FEC_ACC_WRITE 0
`define FEC_ACC_GO 1
`define FEC_ACC_DUMMY 2
// Reset values
`define FEC_RST_CTRL 6'h00
`define FEC_RST_CLK 8'h00
`define FEC_RST_INFO_SEG_A_LOCK 1'b1
// Clock source codes
`define FEC_SRC_AUX 2'h0
`define FEC_SRC_SUBMAIN 2'h1
`define FEC_SRC_MAIN 2'h2
// Timing generator cycles per operation; clock-fail limit in clk_sys_i cycles
`define FEC_ERASE_TICKS 16'h1283
`define FEC_PROG_TICKS 16'h001E
`define FEC_CLKFAIL_LIMIT 8'hFF
// Address layout
`define FEC_INFO_SEGS 4
`define FEC_INFO_SEG_BYTES 64
`define FEC_MAIN_SEG_BYTES 512
`define FEC_BLOCK_BYTES 64
`endif

// file: sim/fec_erase_checker_properties.sv
// Port assertions for the flash erase controller.
// Assumes clk_en_i is held high throughout.
`timescale 1ns/1ps
module fec_erase_checker (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic busy_o,
	input wire logic cpu_stall_o,
	input wire logic timing_clock_on_o,
	input wire logic prog_voltage_on_o,
	input wire logic erase_pulse_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_wait;
		!pready_o ##1 pready_o;
	endsequence
	sequence s_end;
		$past(busy_o) ##1 !busy_o;
	endsequence
	property p_wait;
		$rose(penable_i) && psel_i |-> s_wait;
	endproperty
	a_wait: assert property (p_wait) else $error("late ready");
	property p_err;
		pslverr_o |-> pready_o;
	endproperty
	a_err: assert property (p_err) else $error("lone error");
	property p_ready;
		pready_o |=> !pready_o;
	endproperty
	a_ready: assert property (p_ready) else $error("long ready");
	property p_start;
		$rose(busy_o) |-> $past(pready_o) || $past(pready_o, 2);
	endproperty
	a_start: assert property (p_start) else $error("busy no go");
	property p_tclk;
		busy_o |-> timing_clock_on_o;
	endproperty
	a_tclk: assert property (p_tclk) else $error("clock off");
	property p_stall;
		cpu_stall_o |-> busy_o;
	endproperty
	a_stall: assert property (p_stall) else $error("idle stall");
	property p_end;
		erase_pulse_o |-> s_end;
	endproperty
	a_end: assert property (p_end) else $error("busy kept");
	property p_idle;
		!busy_o && !$past(busy_o) |-> !prog_voltage_on_o;
	endproperty
	a_idle: assert property (p_idle) else $error("idle voltage");
endmodule // fec_erase_checker
bind fec_flash_erase_controller fec_erase_checker chk_u (.*);

// file: sim/fec_cpu_model.sv
// CPU core model issuing APB register transfers.
// Assumes xfer is entered just after a rising clock edge.
`timescale 1ns/1ps
module fec_cpu_model (
	input wire logic clk_sys_i,
	input wire logic pready_i,
	input wire logic pslverr_i,
	input wire logic [31:0] prdata_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [11:0] paddr_o,
	output logic [31:0] pwdata_o
);
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 12'h000;
		pwdata_o = 32'h0;
	end
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r,
		output logic err, output logic ok);
		int n;
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_sys_i);
		penable_o <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (pready_i !== 1'b1 && n < 64);
		r = prdata_i;
		err = pslverr_i;
		ok = pready_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		paddr_o <= ~a;
		pwdata_o <= ~d;
		@(posedge clk_sys_i);
	endtask
endmodule // fec_cpu_model

// file: sim/tb.sv
// Self-checking bench for the flash erase controller.
// Assumes fec_cpu_model drives the APB side.
`timescale 1ns/1ps
module tb;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic src = 1'b0;
	logic src_run = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, last_err;
	logic busy, stall, volt, pulse, tclk, ppulse;
	logic [12:0] prog_addr;
	logic [7:0] prog_mask;
	logic [31:0] pp_addr, pp_mask;
	int ppulses = 0;
	logic [11:0] paddr;
	logic [12:0] base, len;
	logic [31:0] pwdata, prdata, p_base, p_len;
	int failures = 0;
	int samples_checked = 0;
	int pulses = 0;
	always #12.5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		if (src_run)
			src <= ~src;
		if (pulse === 1'b1) begin
			pulses <= pulses + 1;
			p_base <= {19'h0, base};
			p_len <= {19'h0, len};
		end
		if (ppulse === 1'b1) begin
			ppulses <= ppulses + 1;
			pp_addr <= {19'h0, prog_addr};
			pp_mask <= {24'h0, prog_mask};
		end
	end
	fec_flash_erase_controller dut_u (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
		.aux_clock_i(src), .sub_main_clock_i(src), .main_clock_i(src),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .busy_o(busy),
		.cpu_stall_o(stall), .timing_clock_on_o(tclk),
		.prog_voltage_on_o(volt), .erase_pulse_o(pulse),
		.erase_base_o(base), .erase_len_o(len), .program_pulse_o(ppulse),
		.program_addr_o(prog_addr), .program_mask_o(prog_mask)
	);
	fec_cpu_model cpu_u (
		.clk_sys_i(clk_sys_i), .pready_i(pready), .pslverr_i(pslverr),
		.prdata_i(prdata), .psel_o(psel), .penable_o(penable),
		.pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata)
	);
	task automatic print_verdict();
		$display("checks=%0d failures=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		logic ok;
		cpu_u.xfer(w, a, d, r, last_err, ok);
		if (ok !== 1'b1) begin
			failures++;
			print_verdict();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		cmp(r & m, e);
	endtask
	task automatic go(input logic [31:0] ctl, input logic [31:0] a);
		wr(12'h000, ctl);
		wr(12'h00C, a);
		wr(12'h014, 32'h6);
	endtask
	task automatic ignored(input logic [31:0] ctl, input logic [31:0] a);
		go(ctl, a);
		repeat (3) @(posedge clk_sys_i);
		cmp({31'h0, busy}, 32'h0);
		rd(12'h008, 32'h7, 32'h0);
	endtask
	task automatic erase(input logic [31:0] ctl, input logic [31:0] a,
		input logic [31:0] b, input logic [31:0] l);
		int n;
		int p0;
		p0 = pulses;
		go(ctl, a);
		cmp({31'h0, busy}, 32'h1);
		cmp({31'h0, tclk}, 32'h1);
		cmp({31'h0, stall}, {31'h0, ctl[4]});
		@(posedge clk_sys_i);
		if (!ctl[4]) begin
			rd(12'h014, 32'h0, 32'h0);
			rd(12'h008, 32'h5, 32'h5);
		end
		n = 0;
		while (pulses == p0 && n < 20000) begin
			@(posedge clk_sys_i);
			n++;
		end
		if (n == 20000) begin
			failures++;
			print_verdict();
		end
		cmp(p_base, b);
		cmp(p_len, l);
		rd(12'h000, 32'hC, 32'h0);
		rd(12'h008, 32'h1, 32'h0);
		wr(12'h008, 32'h4);
	endtask
	task automatic program_byte();
		int n;
		int p0;
		p0 = ppulses;
		wr(12'h000, 32'h1);
		wr(12'h00C, 32'h120);
		wr(12'h010, 32'h5A);
		wr(12'h014, 32'h6);
		cmp({31'h0, busy}, 32'h1);
		cmp({31'h0, tclk}, 32'h1);
		n = 0;
		while (ppulses == p0 && n < 2000) begin
			@(posedge clk_sys_i);
			n++;
		end
		if (n == 2000) begin
			failures++;
			print_verdict();
		end
		cmp(pp_addr, 32'h120);
		cmp(pp_mask, 32'h5A);
		rd(12'h008, 32'h1, 32'h0);
		rd(12'h000, 32'h1, 32'h1);
		wr(12'h000, 32'h0);
	endtask
	task automatic clk_fail();
		int p0;
		p0 = pulses;
		go(32'h4, 32'h500);
		@(posedge clk_sys_i);
		src_run <= 1'b0;
		repeat (400) @(posedge clk_sys_i);
		rd(12'h008, 32'h3, 32'h2);
		cmp(pulses, p0);
		wr(12'h008, 32'h2);
		src_run <= 1'b1;
	endtask
	initial begin
		repeat (4) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		@(posedge clk_sys_i);
		rd(12'h008, 32'h3F, 32'h8);
		cmp({31'h0, volt}, 32'h0);
		wr(12'h004, 32'h1);
		wr(12'h008, 32'h8);
		rd(12'h008, 32'h8, 32'h0);
		wr(12'h008, 32'h0);
		rd(12'h008, 32'h8, 32'h0);
		wr(12'h008, 32'h8);
		rd(12'h008, 32'h8, 32'h8);
		rd(12'h018, 32'hFFFFFFFF, 32'h0);
		cmp({31'h0, last_err}, 32'h1);
		ignored(32'h4, 32'h10);
		ignored(32'h4, 32'h1F00);
		erase(32'h4, 32'h310, 32'h300, 32'h200);
		erase(32'h14, 32'h50, 32'h40, 32'h40);
		erase(32'h8, 32'h100, 32'h100, 32'h1000);
		erase(32'hC, 32'h100, 32'h100, 32'h1000);
		wr(12'h008, 32'h8);
		erase(32'hC, 32'h100, 32'h0, 32'h1100);
		program_byte();
		clk_fail();
		print_verdict();
	end
endmodule // tb
